// ### sim/ptr_host_model.sv
// Serial bus host model with a pulled-up open-drain data line.
`timescale 1ns/1ps
module ptr_host_model (
    input wire logic clk,
    input wire logic sda_oe,
    output logic scl,
    output logic sda,
    output logic rd_valid,
    output logic [15:0] rd_word
);
    logic host_sda;
    // The pull-up wins whenever neither side pulls the line low.
    assign sda = host_sda & ~sda_oe;
    initial begin
        scl = 1'b1;
        host_sda = 1'b1;
        rd_valid = 1'b0;
        rd_word = 16'h0;
    end
    task automatic half();
        repeat (5) @(posedge clk);
        #2;
    endtask : half
    task automatic start();
        host_sda = 1'b1; half(); scl = 1'b1; half(); host_sda = 1'b0; half(); scl = 1'b0; half();
    endtask : start
    task automatic stop();
        host_sda = 1'b0; half(); scl = 1'b1; half(); host_sda = 1'b1; half();
    endtask : stop
    task automatic bit_io(input logic b, output logic got);
        host_sda = b; half(); scl = 1'b1; half(); got = sda; half(); scl = 1'b0; half();
    endtask : bit_io
    task automatic send(input logic [7:0] v, output logic nack);
        for (int i = 7; i >= 0; i--) bit_io(v[i], nack);
        bit_io(1'b1, nack);
    endtask : send
    task automatic recv(input logic last, output logic [7:0] v);
        logic g;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(last, g);
    endtask : recv
    task automatic read_word(input logic [7:0] sub);
        logic n;
        logic [7:0] lo;
        logic [7:0] hi;
        start(); send({ptr_pkg::DEV_ADDR, 1'b0}, n); send(ptr_pkg::CMD_READ, n);
        send(sub, n); send(sub, n);
        start(); send({ptr_pkg::DEV_ADDR, 1'b1}, n);
        recv(1'b0, lo); recv(1'b1, hi); stop();
        rd_word = {hi, lo};
        rd_valid = 1'b1;
        @(posedge clk);
        #2 rd_valid = 1'b0;
    endtask : read_word
    task automatic write3(input logic [7:0] cmd, input logic [7:0] b1, input logic [7:0] b2);
        logic n;
        start(); send({ptr_pkg::DEV_ADDR, 1'b0}, n); send(cmd, n); send(b1, n); send(b2, n);
        stop();
    endtask : write3
    task automatic probe(input logic [7:0] addr, output logic nack);
        start(); send(addr, nack); stop();
    endtask : probe
endmodule : ptr_host_model

// ### sim/ptr_telemetry_monitor.sv
// Bound checker for the serial data line and the current set-point ports.
`timescale 1ns/1ps
module ptr_telemetry_monitor (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic SCL_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE_OUT,
    input wire logic CUR_VALID_IN,
    input wire logic CC_LIMIT_OUT,
    input wire logic [7:0] CC_SETPOINT_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    a_reset_setpoint: assert property (RESET_IN |=> CC_SETPOINT_OUT == 8'hc0)
        else $error("set-point not restored by reset");
    a_reset_quiet: assert property (RESET_IN |=> !SDA_OE_OUT && !CC_LIMIT_OUT)
        else $error("bus or limit active during reset");
    a_sda_zero: assert property (disable iff (RESET_IN) SDA_OUT == 1'b0)
        else $error("data line value not open drain");
    a_oe_rise_low: assert property (disable iff (RESET_IN) $rose(SDA_OE_OUT) |-> !SCL_IN)
        else $error("data line pulled while clock high");
    a_oe_fall_low: assert property (disable iff (RESET_IN) $fell(SDA_OE_OUT) |-> !SCL_IN)
        else $error("data line released while clock high");
    a_oe_hold_high: assert property (disable iff (RESET_IN)
        $rose(SCL_IN) |=> $stable(SDA_OE_OUT) [*4])
        else $error("data line moved during clock high");
    a_setpoint_scl: assert property (disable iff (RESET_IN)
        $changed(CC_SETPOINT_OUT) && !$past(RESET_IN) |-> SCL_IN)
        else $error("set-point changed outside a clock high phase");
    a_limit_cause: assert property (disable iff (RESET_IN)
        $changed(CC_LIMIT_OUT) && !$past(RESET_IN) && !$past(RESET_IN, 2)
        |-> $past(CUR_VALID_IN, 2) || ($past(CC_SETPOINT_OUT) != $past(CC_SETPOINT_OUT, 2)))
        else $error("limit changed without new average or set-point");
endmodule : ptr_telemetry_monitor

bind ptr_telemetry_bank ptr_telemetry_monitor u_mon (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN),
    .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .CUR_VALID_IN(CUR_VALID_IN),
    .CC_LIMIT_OUT(CC_LIMIT_OUT), .CC_SETPOINT_OUT(CC_SETPOINT_OUT));

// ### sim/tb.sv
// Self-checking testbench for the telemetry read-back bank.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp); end end
module tb;
    logic CLK_IN = 1'b0, RESET_IN = 1'b1, READY_IN = 1'b0, CUR_VALID_IN = 1'b0;
    logic VOLT_VALID_IN = 1'b0, SCL_IN, SDA_IN, SDA_OUT, SDA_OE_OUT, CC_LIMIT_OUT, rd_valid, nack;
    logic [15:0] STATUS_IN = '0, FAULT_IN = '0, IRQ_IN = '0, DAC_IN = '0, rd_word, rnd, f1, exp_w;
    logic [2:0] MODE_FLAGS_IN = '0;
    logic [7:0] CUR_SAMPLE_IN = '0, CC_SETPOINT_OUT;
    logic [11:0] VOLT_SAMPLE_IN = '0;
    logic [11:0] hist [2][16];
    logic [15:0] exp_q [$];
    int num_errors = 0, comparisons = 0;
    always #10 CLK_IN = ~CLK_IN;
    ptr_telemetry_bank dut (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .SCL_IN(SCL_IN),
        .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_OUT(SDA_OE_OUT), .READY_IN(READY_IN),
        .STATUS_IN(STATUS_IN), .FAULT_IN(FAULT_IN), .MODE_FLAGS_IN(MODE_FLAGS_IN),
        .IRQ_IN(IRQ_IN), .DAC_IN(DAC_IN), .CUR_VALID_IN(CUR_VALID_IN),
        .CUR_SAMPLE_IN(CUR_SAMPLE_IN), .VOLT_VALID_IN(VOLT_VALID_IN),
        .VOLT_SAMPLE_IN(VOLT_SAMPLE_IN), .CC_LIMIT_OUT(CC_LIMIT_OUT),
        .CC_SETPOINT_OUT(CC_SETPOINT_OUT));
    ptr_host_model host (.clk(CLK_IN), .sda_oe(SDA_OE_OUT), .scl(SCL_IN), .sda(SDA_IN),
        .rd_valid(rd_valid), .rd_word(rd_word));
    // -------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    function automatic logic [11:0] avg(input int k);
        int s = 0;
        for (int i = 0; i < 16; i++) s += hist[k][i];
        return 12'(s / 16);
    endfunction : avg
    function automatic logic [15:0] stat_exp(input logic [15:0] s, input logic r);
        return (s & ptr_pkg::STATUS_MASK & ~16'h4000) | (16'(r) << ptr_pkg::STATUS_READY_BIT);
    endfunction : stat_exp
    function automatic logic [15:0] fault_exp(input logic [15:0] f);
        return (f & ptr_pkg::FAULT_MASK) | ((|(f & 16'h00f7)) ? 16'h0080 : 16'h0000);
    endfunction : fault_exp
    task automatic do_reset();
        @(posedge CLK_IN); #2 RESET_IN = 1'b1;
        repeat (5) @(posedge CLK_IN);
        #2 RESET_IN = 1'b0;
        foreach (hist[a, b]) hist[a][b] = '0;
        repeat (6) @(posedge CLK_IN);
        #2;
    endtask : do_reset
    task automatic feed(input int k, input logic [11:0] x);
        if (k == 1) begin VOLT_SAMPLE_IN = x; VOLT_VALID_IN = 1'b1; end
        else begin CUR_SAMPLE_IN = x[7:0]; CUR_VALID_IN = 1'b1; end
        for (int i = 15; i > 0; i--) hist[k][i] = hist[k][i-1];
        hist[k][0] = (k == 1) ? x : {4'h0, x[7:0]};
        @(posedge CLK_IN); #2 CUR_VALID_IN = 1'b0; VOLT_VALID_IN = 1'b0;
        @(posedge CLK_IN); #2;
    endtask : feed
    task automatic rd_chk(input logic [7:0] sub, input logic [15:0] e);
        exp_q.push_back(e);
        host.read_word(sub);
    endtask : rd_chk
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    // Each completed read is matched against the oldest expected word.
    always @(posedge rd_valid) begin
        if (exp_q.size() == 0) begin num_errors++; $display("[FAIL] %0t unexpected read", $time); end
        else begin
            exp_w = exp_q.pop_front();
            `CHK(rd_word, exp_w)
        end
    end
    initial begin
        #1ms num_errors++;
        print_verdict();
    end
    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        logic [7:0] offs [4];
        logic [15:0] exps [4];
        rnd = 16'hb71e;
        do_reset();
        rd_chk(ptr_pkg::OFS_INSTANT_STATUS, 16'h0000);
        READY_IN = 1'b1;
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd); STATUS_IN = rnd;
            rd_chk(ptr_pkg::OFS_INSTANT_STATUS, stat_exp(rnd, 1'b1));
        end
        offs = '{8'h16, 8'h1c, 8'h22, 8'h24};
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd); MODE_FLAGS_IN = rnd[2:0]; IRQ_IN = rnd; DAC_IN = ~rnd;
            exps = '{{13'h0, rnd[2:0]}, ~rnd, rnd, 16'h0000};
            rd_chk(offs[k], exps[k]);
        end
        host.probe(8'h32, nack); `CHK(nack, 1'b1)
        for (int i = 0; i < 20; i++) begin
            rnd = lfsr_next(rnd); feed(0, rnd[11:0]); feed(1, rnd[15:4]);
        end
        rd_chk(ptr_pkg::OFS_AVERAGE_OUTPUT_CURRENT, {8'h00, 8'(avg(0))});
        rd_chk(ptr_pkg::OFS_AVERAGE_OUTPUT_VOLTAGE, {4'h0, avg(1)});
        rnd = lfsr_next(rnd); f1 = rnd; FAULT_IN = rnd;
        repeat (5) @(posedge CLK_IN);
        #2 rnd = lfsr_next(rnd); FAULT_IN = rnd;
        repeat (5) @(posedge CLK_IN);
        #2 FAULT_IN = '0;
        rd_chk(ptr_pkg::OFS_FAULT_HISTORY, fault_exp(f1 | rnd));
        do_reset();
        rd_chk(ptr_pkg::OFS_INSTANT_STATUS, stat_exp(STATUS_IN, 1'b1));
        rd_chk(ptr_pkg::OFS_FAULT_HISTORY, 16'h0000);
        host.write3(ptr_pkg::CMD_CC_SET, 8'he0, 8'h80);
        `CHK(CC_SETPOINT_OUT, 8'h60)
        feed(0, 12'h0ff);
        `CHK(CC_LIMIT_OUT, 1'b0)
        for (int i = 0; i < 16; i++) feed(0, 12'h070);
        `CHK(CC_LIMIT_OUT, 1'b1)
        feed(0, 12'h000);
        `CHK(CC_LIMIT_OUT, 1'b1)
        feed(0, 12'h000);
        feed(0, 12'h000);
        `CHK(CC_LIMIT_OUT, 1'b0)
        for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge CLK_IN);
        if (exp_q.size() > 0) num_errors++;
        print_verdict();
    end
endmodule : tb

// ### src/ptr_avg.sv
// Running average over the last 2**LOG2 samples.
`timescale 1ns/1ps
module ptr_avg #(
    parameter int W = 8,
    parameter int LOG2 = 4
) (
    input wire logic clk,
    input wire logic rst,
    ptr_avg_if.calc avg
);
    localparam int N = 1 << LOG2;
    logic [W-1:0] hist_r [N];
    logic [LOG2-1:0] idx_r;
    logic [W+LOG2-1:0] sum_r;
    logic [W+LOG2-1:0] sum_nxt;
    logic [W-1:0] avg_r;

    // The oldest sample leaves the window as the new one enters.
    assign sum_nxt = sum_r + (W+LOG2)'(avg.sample) - (W+LOG2)'(hist_r[idx_r]);
    assign avg.average = avg_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                hist_r[i] <= '0;
            end
            idx_r <= '0;
            sum_r <= '0;
            avg_r <= '0;
        end else if (avg.valid) begin
            hist_r[idx_r] <= avg.sample;
            idx_r <= idx_r + 1'b1;
            sum_r <= sum_nxt;
            avg_r <= sum_nxt[W+LOG2-1:LOG2];
        end
    end
endmodule : ptr_avg

// ### src/ptr_avg_if.sv
// Sample stream and average result between the bank and an averager.
`timescale 1ns/1ps
interface ptr_avg_if #(parameter int W = 8);
    logic valid;
    logic [W-1:0] sample;
    logic [W-1:0] average;
    modport feed (output valid, output sample, input average);
    modport calc (input valid, input sample, output average);
endinterface : ptr_avg_if

// ### src/ptr_pkg.sv
// Constants for the power telemetry read-back register bank.
package ptr_pkg;
    // -------------------------------------------------------------
    // Bus addressing
    // -------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR = 7'h18;
    localparam logic [7:0] CMD_READ = 8'h80;
    localparam logic [7:0] CMD_CC_SET = 8'h98;
    // -------------------------------------------------------------
    // Register sub-addresses
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_INSTANT_STATUS = 8'h14;
    localparam logic [7:0] OFS_OPERATING_MODE_FLAGS = 8'h16;
    localparam logic [7:0] OFS_AVERAGE_OUTPUT_CURRENT = 8'h18;
    localparam logic [7:0] OFS_AVERAGE_OUTPUT_VOLTAGE = 8'h1a;
    localparam logic [7:0] OFS_VOLTAGE_DAC_READBACK = 8'h1c;
    localparam logic [7:0] OFS_FAULT_HISTORY = 8'h20;
    localparam logic [7:0] OFS_INTERRUPT_STATUS_MASK = 8'h22;
    // -------------------------------------------------------------
    // Field layouts
    // -------------------------------------------------------------
    localparam logic [15:0] STATUS_MASK = 16'hf63f;
    localparam int STATUS_READY_BIT = 14;
    localparam logic [15:0] FAULT_MASK = 16'h9e77;
    localparam logic [15:0] FAULT_LATCH_GROUP = 16'h0077;
    localparam int FAULT_ANY_LATCH_BIT = 7;
    localparam logic [15:0] OMF_MASK = 16'h0007;
    localparam int CUR_W = 8;
    localparam int VOLT_W = 12;
    localparam int AVG_LOG2 = 4;
    // -------------------------------------------------------------
    // Current set-point: data in low bits 6:0 and high bit 8
    // -------------------------------------------------------------
    localparam logic [7:0] CC_SET_RESET = 8'hc0;
    localparam int CC_LOW_DATA_MSB = 6;
    localparam int CC_HIGH_DATA_BIT = 0;
endpackage : ptr_pkg

// ### src/ptr_telemetry_bank.sv
// Telemetry read-back register bank behind a two-wire serial slave.
//
// Notes on behaviour
// - Status word bits 15,14,13,12,10,9: irq enable, ready, discharge, fast, auto-CV, OTP.
// - Status word low bits 5..0: bleeder, output high, sense short, short, UV, OV.
// - Word 0x18 reads zero above bit 7; low byte averages 16 current samples.
// - Word 0x1A reads zero above bit 11; low bits average 16 voltage samples.
// - Fault word records auto-restart events in bits 15, 12, 11, 10, 9.
// - Fault word records latch-offs in bits 6..4, 2..0; bit 7 means any latch-off.
// - Ready bit is one only while the device can accept bus commands.
// - Sub-address written into command 0x80 selects the word read back; ready at bit 14.
// - Current limit compares the averaged current, never the instantaneous sample.
`timescale 1ns/1ps
module ptr_telemetry_bank (
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_OUT,
    input wire logic READY_IN,
    input wire logic [15:0] STATUS_IN,
    input wire logic [15:0] FAULT_IN,
    input wire logic [2:0] MODE_FLAGS_IN,
    input wire logic [15:0] IRQ_IN,
    input wire logic [15:0] DAC_IN,
    input wire logic CUR_VALID_IN,
    input wire logic [7:0] CUR_SAMPLE_IN,
    input wire logic VOLT_VALID_IN,
    input wire logic [11:0] VOLT_SAMPLE_IN,
    output logic CC_LIMIT_OUT,
    output logic [7:0] CC_SETPOINT_OUT
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_WBYTE, ST_ACK_WAIT, ST_ACK, ST_RBYTE, ST_RACK, ST_RNEXT
    } ptr_state_t;

    // -------------------------------------------------------------
    // Pin synchronisers
    // -------------------------------------------------------------
    logic scl_s1_r, scl_s2_r, scl_d_r;
    logic sda_s1_r, sda_s2_r, sda_d_r;
    logic rdy_s1_r, rdy_s2_r;
    logic [15:0] stat_s1_r, stat_s2_r;
    logic [15:0] flt_s1_r, flt_s2_r;
    logic [2:0] omf_s1_r, omf_s2_r;
    logic [15:0] irq_s1_r, irq_s2_r;

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            {scl_s1_r, scl_s2_r, scl_d_r} <= 3'h7;
            {sda_s1_r, sda_s2_r, sda_d_r} <= 3'h7;
            {rdy_s1_r, rdy_s2_r} <= 2'h0;
            {stat_s1_r, stat_s2_r, flt_s1_r, flt_s2_r} <= '0;
            {omf_s1_r, omf_s2_r, irq_s1_r, irq_s2_r} <= '0;
        end else begin
            {scl_s1_r, scl_s2_r, scl_d_r} <= {SCL_IN, scl_s1_r, scl_s2_r};
            {sda_s1_r, sda_s2_r, sda_d_r} <= {SDA_IN, sda_s1_r, sda_s2_r};
            {rdy_s1_r, rdy_s2_r} <= {READY_IN, rdy_s1_r};
            {stat_s1_r, stat_s2_r} <= {STATUS_IN, stat_s1_r};
            {flt_s1_r, flt_s2_r} <= {FAULT_IN, flt_s1_r};
            {omf_s1_r, omf_s2_r} <= {MODE_FLAGS_IN, omf_s1_r};
            {irq_s1_r, irq_s2_r} <= {IRQ_IN, irq_s1_r};
        end
    end

    // Edges and bus conditions are taken from the synchronised lines only.
    wire scl_rise = scl_s2_r & ~scl_d_r;
    wire scl_fall = ~scl_s2_r & scl_d_r;
    wire bus_start = scl_s2_r & scl_d_r & ~sda_s2_r & sda_d_r;
    wire bus_stop = scl_s2_r & scl_d_r & sda_s2_r & ~sda_d_r;

    // -------------------------------------------------------------
    // Averagers
    // -------------------------------------------------------------
    ptr_avg_if #(.W(ptr_pkg::CUR_W)) cur_if ();
    ptr_avg_if #(.W(ptr_pkg::VOLT_W)) volt_if ();
    assign cur_if.valid = CUR_VALID_IN;
    assign cur_if.sample = CUR_SAMPLE_IN;
    assign volt_if.valid = VOLT_VALID_IN;
    assign volt_if.sample = VOLT_SAMPLE_IN;

    ptr_avg #(.W(ptr_pkg::CUR_W), .LOG2(ptr_pkg::AVG_LOG2)) u_cur_avg (
        .clk(CLK_IN),
        .rst(RESET_IN),
        .avg(cur_if.calc)
    );
    ptr_avg #(.W(ptr_pkg::VOLT_W), .LOG2(ptr_pkg::AVG_LOG2)) u_volt_avg (
        .clk(CLK_IN),
        .rst(RESET_IN),
        .avg(volt_if.calc)
    );

    // -------------------------------------------------------------
    // Register contents
    // -------------------------------------------------------------
    logic ready_r;
    logic [15:0] fault_r;
    logic [15:0] fault_nxt;
    logic [7:0] cc_set_r;
    logic cc_limit_r;

    // A latch-off of any kind also sets the summary bit.
    wire [15:0] fault_evt = flt_s2_r & ptr_pkg::FAULT_MASK;
    wire any_latch = |(fault_evt & ptr_pkg::FAULT_LATCH_GROUP);
    always_comb begin
        fault_nxt = fault_r | fault_evt;
        fault_nxt[ptr_pkg::FAULT_ANY_LATCH_BIT] = fault_r[ptr_pkg::FAULT_ANY_LATCH_BIT] |
            flt_s2_r[ptr_pkg::FAULT_ANY_LATCH_BIT] |
            any_latch;
    end

    wire [15:0] status_word = {(stat_s2_r[15] & ptr_pkg::STATUS_MASK[15]), ready_r,
        stat_s2_r[13:0] & ptr_pkg::STATUS_MASK[13:0]};
    wire [15:0] cur_word = {8'h00, cur_if.average};
    wire [15:0] volt_word = {4'h0, volt_if.average};
    wire [15:0] omf_word = {13'h0000, omf_s2_r} & ptr_pkg::OMF_MASK;

    // -------------------------------------------------------------
    // Serial slave
    // -------------------------------------------------------------
    ptr_state_t state_r, state_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic rw_r, rw_nxt;
    logic ack_ok_r, ack_ok_nxt;
    logic [1:0] byte_idx_r, byte_idx_nxt;
    logic [7:0] cmd_r, cmd_nxt;
    logic [7:0] sub_r, sub_nxt;
    logic [7:0] cc_low_r, cc_low_nxt;
    logic [7:0] cc_set_nxt;
    logic hi_sel_r, hi_sel_nxt;
    logic oe_r, oe_nxt;

    wire [7:0] got = {shift_r[6:0], sda_s2_r};

    // The word seen by a read is chosen by the stored sub-address.
    // A sub-address that maps to no register reads back as zero.
    wire sel_stat = sub_r == ptr_pkg::OFS_INSTANT_STATUS;
    wire sel_omf = sub_r == ptr_pkg::OFS_OPERATING_MODE_FLAGS;
    wire sel_cur = sub_r == ptr_pkg::OFS_AVERAGE_OUTPUT_CURRENT;
    wire sel_volt = sub_r == ptr_pkg::OFS_AVERAGE_OUTPUT_VOLTAGE;
    wire sel_dac = sub_r == ptr_pkg::OFS_VOLTAGE_DAC_READBACK;
    wire sel_flt = sub_r == ptr_pkg::OFS_FAULT_HISTORY;
    wire sel_irq = sub_r == ptr_pkg::OFS_INTERRUPT_STATUS_MASK;
    wire [15:0] rd_word = ({16{sel_stat}} & status_word) | ({16{sel_omf}} & omf_word) |
        ({16{sel_cur}} & cur_word) | ({16{sel_volt}} & volt_word) |
        ({16{sel_dac}} & DAC_IN) | ({16{sel_flt}} & fault_r) |
        ({16{sel_irq}} & irq_s2_r);
    wire [7:0] rd_byte = hi_sel_r ? rd_word[15:8] : rd_word[7:0];

    // A start or stop condition overrides whatever byte is in progress.
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        rw_nxt = rw_r;
        ack_ok_nxt = ack_ok_r;
        byte_idx_nxt = byte_idx_r;
        cmd_nxt = cmd_r;
        sub_nxt = sub_r;
        cc_low_nxt = cc_low_r;
        cc_set_nxt = cc_set_r;
        hi_sel_nxt = hi_sel_r;
        oe_nxt = oe_r;
        if (bus_start) begin
            state_nxt = ST_ADDR;
            cnt_nxt = 3'h0;
            oe_nxt = 1'b0;
        end else if (bus_stop) begin
            state_nxt = ST_IDLE;
            oe_nxt = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                end
                ST_ADDR, ST_WBYTE: begin
                    if (scl_rise) begin
                        shift_nxt = got;
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == 3'h7) begin
                            state_nxt = ST_ACK_WAIT;
                            if (state_r == ST_ADDR) begin
                                ack_ok_nxt = got[7:1] == ptr_pkg::DEV_ADDR;
                                rw_nxt = got[0];
                                byte_idx_nxt = 2'h0;
                                hi_sel_nxt = 1'b0;
                            end else begin
                                ack_ok_nxt = 1'b1;
                                if (byte_idx_r != 2'h3) begin
                                    byte_idx_nxt = byte_idx_r + 2'h1;
                                end
                                if (byte_idx_r == 2'h0) begin
                                    cmd_nxt = got;
                                end else if (cmd_r == ptr_pkg::CMD_READ) begin
                                    sub_nxt = got;
                                end else if (cmd_r == ptr_pkg::CMD_CC_SET) begin
                                    if (byte_idx_r == 2'h1) begin
                                        cc_low_nxt = got;
                                    end else if (byte_idx_r == 2'h2) begin
                                        cc_set_nxt = {got[ptr_pkg::CC_HIGH_DATA_BIT],
                                            cc_low_r[ptr_pkg::CC_LOW_DATA_MSB:0]};
                                    end
                                end
                            end
                        end
                    end
                end
                ST_ACK_WAIT: begin
                    if (scl_fall) begin
                        oe_nxt = ack_ok_r;
                        state_nxt = ack_ok_r ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 3'h0;
                        if (rw_r) begin
                            shift_nxt = rd_byte;
                            oe_nxt = ~rd_byte[7];
                            hi_sel_nxt = ~hi_sel_r;
                            state_nxt = ST_RBYTE;
                        end else begin
                            oe_nxt = 1'b0;
                            state_nxt = ST_WBYTE;
                        end
                    end
                end
                // Read data moves only after a clock fall, so it is stable while high.
                ST_RBYTE: begin
                    if (scl_fall) begin
                        if (cnt_r == 3'h7) begin
                            oe_nxt = 1'b0;
                            state_nxt = ST_RACK;
                        end else begin
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt = ~shift_r[6];
                            cnt_nxt = cnt_r + 3'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        state_nxt = sda_s2_r ? ST_IDLE : ST_RNEXT;
                    end
                end
                ST_RNEXT: begin
                    if (scl_fall) begin
                        cnt_nxt = 3'h0;
                        shift_nxt = rd_byte;
                        oe_nxt = ~rd_byte[7];
                        hi_sel_nxt = ~hi_sel_r;
                        state_nxt = ST_RBYTE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            state_r <= ST_IDLE;
            {shift_r, cnt_r, rw_r, ack_ok_r, byte_idx_r, hi_sel_r, oe_r} <= '0;
            {cmd_r, sub_r, cc_low_r} <= '0;
            cc_set_r <= ptr_pkg::CC_SET_RESET;
        end else begin
            state_r <= state_nxt;
            {shift_r, cnt_r, rw_r, ack_ok_r} <= {shift_nxt, cnt_nxt, rw_nxt, ack_ok_nxt};
            {byte_idx_r, hi_sel_r, oe_r} <= {byte_idx_nxt, hi_sel_nxt, oe_nxt};
            {cmd_r, sub_r, cc_low_r, cc_set_r} <= {cmd_nxt, sub_nxt, cc_low_nxt, cc_set_nxt};
        end
    end

    // -------------------------------------------------------------
    // Status, fault history and current limit
    // -------------------------------------------------------------
    // The limit follows the averaged current, so one high sample moves its input by at most a sixteenth of that sample.
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            ready_r <= 1'b0;
            fault_r <= '0;
            cc_limit_r <= 1'b0;
        end else begin
            ready_r <= rdy_s2_r;
            fault_r <= fault_nxt;
            cc_limit_r <= cur_if.average >= cc_set_r;
        end
    end

    // -------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------
    assign SDA_OUT = 1'b0;
    assign SDA_OE_OUT = oe_r;
    assign CC_LIMIT_OUT = cc_limit_r;
    assign CC_SETPOINT_OUT = cc_set_r;
endmodule : ptr_telemetry_bank
